// file: dio_capture_defs.svh
// register offsets, field positions, reset values and timing counts of the line block
`ifndef DIO_CAPTURE_DEFS_SVH
`define DIO_CAPTURE_DEFS_SVH

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_DIVISOR    8'h08
`define OFS_DELAY      8'h0c
`define OFS_TOTAL      8'h10
`define OFS_PRETRIG    8'h14
`define OFS_SRCSEL     8'h18
`define OFS_DIR_LO     8'h1c
`define OFS_DIR_HI     8'h20
`define OFS_OUT_LO     8'h24
`define OFS_OUT_HI     8'h28
`define OFS_IN_LO      8'h2c
`define OFS_IN_HI      8'h30
`define OFS_CAPEN      8'h34
`define OFS_EXPORT     8'h38
`define OFS_DMA_BASE   8'h3c
`define OFS_DMA_SENT   8'h40
`define OFS_TSP_DATA   8'h44

// control fields
`define CTRL_ARM       0
`define CTRL_STOP      1
`define CTRL_EXT_STB   2
`define CTRL_STB_FALL  3
`define CTRL_MODE_LO   4
`define CTRL_MODE_HI   5
`define CTRL_REF_EN    6
`define CTRL_RETRIG    7
`define CTRL_HOLD_HIGH 8
`define CTRL_BEG_EN    9
`define CTRL_BEG_FALL  10
`define CTRL_REF_FALL  11
`define CTRL_FILT_LO   12
`define CTRL_FILT_HI   15

// status fields
`define STAT_RUN       0
`define STAT_OVF       1
`define STAT_LATE      2
`define STAT_CFGERR    3
`define STAT_EMPTY     4
`define STAT_FULL      5

`define EXPORT_EN      8

// reset values
`define CTRL_RST       16'h0000
`define DIVISOR_RST    32'h00000064
`define DELAY_RST      32'h00000002
`define TOTAL_RST      32'h00000400
`define PRETRIG_RST    32'h00000000

// timing: 200 MHz clock, input filter holds a level for at least FILTER_NS
`define CLK_MHZ        200
`define FILTER_NS      100
`define FILTER_CYC     ((`FILTER_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: dio_capture_pkg.sv
// types shared by the line block: engine states and sample modes
package dio_capture_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_RUN   = 4'b1000
    } cap_state_e;

    typedef enum logic [1:0] {
        MODE_FINITE = 2'h0,
        MODE_CONT   = 2'h1,
        MODE_TSP    = 2'h2
    } cap_mode_e;
endpackage

// file: dio_port_waveform_capture.sv
// 40-line static port with 32-line waveform capture (lines 0 to 31), timing engine, capture FIFO and DMA
`include "dio_capture_defs.svh"
`timescale 1ns/1ps

module dio_port_waveform_capture #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // lines, oe low while driving
    input  wire logic [39:0] lineIn,
    output logic      [39:0] lineOut,
    output logic      [39:0] lineOeN,
    // dma write port to host memory
    output logic             dmaValid,
    output logic      [31:0] dmaAddr,
    output logic      [31:0] dmaData,
    input  wire logic        dmaReady,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import dio_capture_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [7:0] FILT_LAST = 8'(`FILTER_CYC - 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    typedef struct packed {
        cap_state_e                 st;
        logic [39:0]                s1;
        logic [39:0]                s2;
        logic [39:0]                s3;
        logic [39:0]                pin;
        logic [3:0]                 filt;
        logic [3:0][7:0]            fcnt;
        logic                       tbTick;
        logic [31:0]                divCnt;
        logic [31:0]                dlyCnt;
        logic [31:0]                smpCnt;
        logic                       refSeen;
        logic                       stbPrev;
        logic                       begPrev;
        logic                       refPrev;
        logic [15:0]                ctrl;
        logic [31:0]                divisor;
        logic [31:0]                delay;
        logic [31:0]                total;
        logic [31:0]                pre;
        logic [31:0]                srcSel;
        logic [39:0]                dir;
        logic [39:0]                outv;
        logic [31:0]                capEn;
        logic [8:0]                 expSel;
        logic [31:0]                dmaBase;
        logic [31:0]                dmaSent;
        logic                       ovf;
        logic                       late;
        logic                       cfgErr;
        logic                       tspPend;
        logic [31:0]                tspData;
        logic [DEPTH-1:0][31:0]     mem;
        logic [AW-1:0]              wp;
        logic [AW-1:0]              rp;
        logic [AW:0]                cnt;
        logic                       awGot;
        logic                       wGot;
        logic [7:0]                 awAddr;
        logic [31:0]                wData;
        logic [3:0]                 wStrb;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic                       dmaValid;
        logic [31:0]                dmaAddr;
        logic [31:0]                dmaData;
        logic [39:0]                lineOut;
        logic [39:0]                lineOeN;
    } state_s;

    state_s q;
    state_s n;

    // byte-lane merge for register writes
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // picks a line by number; numbers past 39 read low
    function automatic logic pickLine(input logic [39:0] v, input logic [5:0] idx);
        logic r;
        r = 1'b0;
        if (idx < 6'h28) begin
            r = v[idx];
        end
        return r;
    endfunction

    function automatic logic edgeOf(input logic prev, input logic cur, input logic fall);
        return fall ? (prev & ~cur) : (~prev & cur);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    logic [3:0]  raw;
    logic [3:0]  sig;
    logic [31:0] div;
    logic        intLvl;
    logic        stb;
    logic        hold;
    logic        sampleEv;
    logic        begEv;
    logic        refEv;
    logic        pop;
    logic        done;
    logic [AW:0] cntAfter;
    logic [31:0] sample;
    logic [31:0] sentNext;
    cap_mode_e   mode;

    always_comb begin
        n = q;
        mode = cap_mode_e'(q.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]);
        done = 1'b0;
        n.tbTick = ~q.tbTick;

        // pin inputs: three stages, a change counts when stages two and three agree
        n.s1 = lineIn;
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 40; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                n.pin[i] = q.s3[i];
            end
        end

        // strobe, begin, reference, hold sources and their filters
        raw[0] = pickLine(q.pin, q.srcSel[5:0]);
        raw[1] = pickLine(q.pin, q.srcSel[13:8]);
        raw[2] = pickLine(q.pin, q.srcSel[21:16]);
        raw[3] = pickLine(q.pin, q.srcSel[29:24]);
        for (int k = 0; k < 4; k++) begin
            if (!q.ctrl[`CTRL_FILT_LO + k] || raw[k] == q.filt[k]) begin
                n.fcnt[k] = 8'h00;
                n.filt[k] = q.ctrl[`CTRL_FILT_LO + k] ? q.filt[k] : raw[k];
            end else if (q.fcnt[k] == FILT_LAST) begin
                n.fcnt[k] = 8'h00;
                n.filt[k] = raw[k];
            end else begin
                n.fcnt[k] = q.fcnt[k] + 8'h01;
            end
            sig[k] = q.ctrl[`CTRL_FILT_LO + k] ? q.filt[k] : raw[k];
        end

        // strobe generation and selection
        div = (q.divisor < 32'h2) ? 32'h2 : q.divisor;
        intLvl = (q.st == ST_RUN) && (q.divCnt < (div >> 1));
        stb = q.ctrl[`CTRL_EXT_STB] ? sig[0] : intLvl;
        n.stbPrev = stb;
        n.begPrev = sig[1];
        n.refPrev = sig[2];
        hold = (sig[3] == q.ctrl[`CTRL_HOLD_HIGH]);
        sampleEv = edgeOf(q.stbPrev, stb, q.ctrl[`CTRL_STB_FALL])
                   && (q.st == ST_RUN) && !hold;
        begEv = edgeOf(q.begPrev, sig[1], q.ctrl[`CTRL_BEG_FALL]);
        refEv = edgeOf(q.refPrev, sig[2], q.ctrl[`CTRL_REF_FALL]);
        sample = q.pin[31:0] & q.capEn;

        // dma drain of the FIFO
        sentNext = q.dmaSent + {31'h0, q.dmaValid & dmaReady};
        n.dmaSent = sentNext;
        pop = (!q.dmaValid || dmaReady) && (q.cnt != '0);
        if (pop) begin
            n.dmaValid = 1'b1;
            n.dmaData = q.mem[q.rp];
            n.dmaAddr = q.dmaBase + {sentNext[29:0], 2'b00};
            n.rp = q.rp + 1'b1;
        end else if (dmaReady) begin
            n.dmaValid = 1'b0;
        end
        cntAfter = q.cnt - {{AW{1'b0}}, pop};
        n.cnt = cntAfter;

        // axi write channel, address and data in either order
        if (s_axi_awvalid && q.awready) begin
            n.awGot = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            n.wGot = 1'b1;
            n.wData = s_axi_wdata;
            n.wStrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (q.awGot && q.wGot && !q.bvalid) begin
            n.awGot = 1'b0;
            n.wGot = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = 2'h0;
            case ({q.awAddr[7:2], 2'b00})
                `OFS_CTRL: begin
                    n.ctrl = 16'(mergeBytes({16'h0, q.ctrl}, q.wData, q.wStrb) & 32'hfffc);
                    if (q.wStrb[0] && q.wData[`CTRL_STOP]) begin
                        n.st = ST_IDLE;
                    end else if (q.wStrb[0] && q.wData[`CTRL_ARM] && q.st == ST_IDLE) begin
                        if (n.ctrl[`CTRL_REF_EN] && n.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO]
                            != MODE_FINITE) begin
                            n.cfgErr = 1'b1;
                        end else begin
                            n.st = ST_WAIT;
                        end
                    end
                end
                `OFS_STATUS: begin
                    if (q.wStrb[0]) begin
                        n.ovf = q.ovf & ~q.wData[`STAT_OVF];
                        n.late = q.late & ~q.wData[`STAT_LATE];
                        n.cfgErr = q.cfgErr & ~q.wData[`STAT_CFGERR];
                    end
                end
                `OFS_DIVISOR:  n.divisor = mergeBytes(q.divisor, q.wData, q.wStrb);
                `OFS_DELAY:    n.delay = mergeBytes(q.delay, q.wData, q.wStrb);
                `OFS_TOTAL:    n.total = mergeBytes(q.total, q.wData, q.wStrb);
                `OFS_PRETRIG:  n.pre = mergeBytes(q.pre, q.wData, q.wStrb);
                `OFS_SRCSEL:   n.srcSel = mergeBytes(q.srcSel, q.wData, q.wStrb);
                `OFS_DIR_LO:   n.dir[31:0] = mergeBytes(q.dir[31:0], q.wData, q.wStrb);
                `OFS_DIR_HI:   n.dir[39:32] = q.wStrb[0] ? q.wData[7:0] : q.dir[39:32];
                `OFS_OUT_LO:   n.outv[31:0] = mergeBytes(q.outv[31:0], q.wData, q.wStrb);
                `OFS_OUT_HI:   n.outv[39:32] = q.wStrb[0] ? q.wData[7:0] : q.outv[39:32];
                `OFS_CAPEN:    n.capEn = mergeBytes(q.capEn, q.wData, q.wStrb);
                `OFS_EXPORT:   n.expSel = 9'(mergeBytes({23'h0, q.expSel}, q.wData, q.wStrb));
                `OFS_DMA_BASE: n.dmaBase = mergeBytes(q.dmaBase, q.wData, q.wStrb);
                `OFS_DMA_SENT: n.dmaSent = 32'h0;
                default:       n.bresp = 2'h2;
            endcase
        end

        // axi read channel; a read of the single-point sample releases it
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp = 2'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                `OFS_CTRL:     n.rdata = {16'h0, q.ctrl};
                `OFS_STATUS:   n.rdata = {26'h0, q.cnt == DEPTH[AW:0], q.cnt == '0,
                                          q.cfgErr, q.late, q.ovf, q.st != ST_IDLE};
                `OFS_DIVISOR:  n.rdata = q.divisor;
                `OFS_DELAY:    n.rdata = q.delay;
                `OFS_TOTAL:    n.rdata = q.total;
                `OFS_PRETRIG:  n.rdata = q.pre;
                `OFS_SRCSEL:   n.rdata = q.srcSel;
                `OFS_DIR_LO:   n.rdata = q.dir[31:0];
                `OFS_DIR_HI:   n.rdata = {24'h0, q.dir[39:32]};
                `OFS_OUT_LO:   n.rdata = q.outv[31:0];
                `OFS_OUT_HI:   n.rdata = {24'h0, q.outv[39:32]};
                `OFS_IN_LO:    n.rdata = q.pin[31:0];
                `OFS_IN_HI:    n.rdata = {24'h0, q.pin[39:32]};
                `OFS_CAPEN:    n.rdata = q.capEn;
                `OFS_EXPORT:   n.rdata = {23'h0, q.expSel};
                `OFS_DMA_BASE: n.rdata = q.dmaBase;
                `OFS_DMA_SENT: n.rdata = q.dmaSent;
                `OFS_TSP_DATA: begin
                    n.rdata = q.tspData;
                    n.tspPend = 1'b0;
                end
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = 2'h2;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////////////
        // timing engine; flags set here win over a software clear in the same cycle
        case (q.st)
            ST_IDLE: begin
                n.divCnt = 32'h0;
            end
            ST_WAIT: begin
                if (!q.ctrl[`CTRL_BEG_EN] || begEv) begin
                    n.st = q.ctrl[`CTRL_EXT_STB] ? ST_RUN : ST_DELAY;
                    n.dlyCnt = 32'h0;
                    n.smpCnt = 32'h0;
                    n.divCnt = 32'h0;
                    n.refSeen = 1'b0;
                end
            end
            ST_DELAY: begin
                if (q.dlyCnt >= q.delay) begin
                    n.st = ST_RUN;
                    n.dlyCnt = 32'h0;
                end else if (q.tbTick) begin
                    n.dlyCnt = q.dlyCnt + 32'h1;
                end
            end
            ST_RUN: begin
                // the internal divider halts while held
                if (q.tbTick && !hold) begin
                    n.divCnt = (q.divCnt >= div - 32'h1) ? 32'h0 : q.divCnt + 32'h1;
                end
                if (mode == MODE_FINITE && q.ctrl[`CTRL_REF_EN] && refEv && !q.refSeen
                    && q.smpCnt >= q.pre) begin
                    n.refSeen = 1'b1;
                end
                if (sampleEv) begin
                    n.smpCnt = q.smpCnt + 32'h1;
                    if (mode == MODE_TSP) begin
                        if (n.tspPend) begin
                            n.late = 1'b1;
                        end
                        n.tspPend = 1'b1;
                        n.tspData = sample;
                    end else begin
                        n.mem[q.wp] = sample;
                        if (cntAfter == DEPTH[AW:0]) begin
                            n.ovf = 1'b1;
                            if (mode == MODE_CONT || (q.ctrl[`CTRL_REF_EN] && !q.refSeen)) begin
                                n.wp = q.wp + 1'b1;
                                n.rp = n.rp + 1'b1;
                            end else begin
                                n.mem[q.wp] = q.mem[q.wp];
                            end
                        end else begin
                            n.wp = q.wp + 1'b1;
                            n.cnt = cntAfter + 1'b1;
                        end
                    end
                    if (mode == MODE_FINITE) begin
                        if (q.ctrl[`CTRL_REF_EN]) begin
                            if (q.refSeen) begin
                                n.dlyCnt = q.dlyCnt + 32'h1;
                                done = (q.dlyCnt + 32'h1 >= q.total - q.pre);
                            end
                        end else begin
                            done = (q.smpCnt + 32'h1 >= q.total);
                        end
                    end
                end
                if (done) begin
                    // retrigger rearms only once the burst is over
                    n.st = (q.ctrl[`CTRL_RETRIG] && !q.ctrl[`CTRL_REF_EN]) ? ST_WAIT
                                                                           : ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // a stop command outranks the next state the engine decided this cycle
        if (q.awGot && q.wGot && !q.bvalid && {q.awAddr[7:2], 2'b00} == `OFS_CTRL
            && q.wStrb[0] && q.wData[`CTRL_STOP]) begin
            n.st = ST_IDLE;
        end

        // line drivers; an exported strobe goes out inverted
        for (int i = 0; i < 40; i++) begin
            if (q.expSel[`EXPORT_EN] && q.expSel[5:0] == 6'(i)) begin
                n.lineOut[i] = ~stb;
                n.lineOeN[i] = 1'b0;
            end else begin
                n.lineOut[i] = q.outv[i];
                n.lineOeN[i] = ~q.dir[i];
            end
        end

        n.awready = !n.awGot && !n.bvalid;
        n.wready = !n.wGot && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ctrl <= `CTRL_RST;
            q.divisor <= `DIVISOR_RST;
            q.delay <= `DELAY_RST;
            q.total <= `TOTAL_RST;
            q.pre <= `PRETRIG_RST;
            q.lineOeN <= 40'hff_ffff_ffff;
        end else begin
            q <= n;
        end
    end

    assign lineOut = q.lineOut;
    assign lineOeN = q.lineOeN;
    assign dmaValid = q.dmaValid;
    assign dmaAddr = q.dmaAddr;
    assign dmaData = q.dmaData;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
endmodule

// file: dio_capture_monitor.sv
// port checker for the line block
`timescale 1ns/1ps
module dio_capture_monitor (
    input wire logic        clk, sys_rst,
    input wire logic [39:0] lineOeN,
    input wire logic [31:0] dmaAddr, dmaData,
    input wire logic        dmaValid, dmaReady, s_axi_awvalid, s_axi_awready,
    input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_dma_next; dmaValid && dmaReady ##1 dmaValid; endsequence
    // reset must not be masked here, it is the cause being checked
    property p_rst_idle; disable iff (1'b0) sys_rst |=> lineOeN == '1 && !dmaValid; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("drive after reset");
    property p_wr_ans; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("late write answer");
    property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken early");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer repeated");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
    property p_dma_hold; dmaValid && !dmaReady |=> dmaValid && $stable({dmaAddr, dmaData}); endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma word dropped");
    property p_dma_step; s_dma_next |-> dmaAddr == $past(dmaAddr) + 32'h4; endproperty
    a_dma_step: assert property (p_dma_step) else $error("dma address step");
endmodule
bind dio_port_waveform_capture dio_capture_monitor u_mon (.*);

// file: dio_host_mem_model.sv
// host memory model taking dma words
`timescale 1ns/1ps
module dio_host_mem_model (
    input  wire logic        clk, dmaValid,
    input  wire logic [31:0] dmaData,
    input  wire logic [1:0]  pace,
    output logic             dmaReady,
    output logic      [31:0] lastWord,
    output int               wordCount
);
    logic [1:0] tick = 2'h0;
    initial {dmaReady, lastWord, wordCount} = '0;
    // pace 0 prompt, 1 slow (one slot in four), 2 refuses to drain
    always @(posedge clk) begin
        tick <= tick + 2'h1;
        dmaReady <= (pace == 2'h0) || (pace == 2'h1 && tick == 2'h3);
        if (dmaValid && dmaReady) begin
            wordCount <= wordCount + 1;
            lastWord <= dmaData;
        end
    end
endmodule

// file: dio_port_waveform_capture_tb.sv
// self-checking bench for the line block
`timescale 1ns/1ps
`include "dio_capture_defs.svh"
module dio_port_waveform_capture_tb;
    logic        clk, sys_rst, dmaValid, dmaReady, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [39:0] lineIn, lineOut, lineOeN;
    logic [31:0] dmaAddr, dmaData, s_axi_wdata, s_axi_rdata, lastWord, rd;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, pace;
    int          bad_count, checks_done, words;
    dio_port_waveform_capture #(.DEPTH(4)) u_dut (.*);
    dio_host_mem_model u_mem (.clk(clk), .dmaValid(dmaValid), .dmaData(dmaData), .pace(pace),
        .dmaReady(dmaReady), .lastWord(lastWord), .wordCount(words));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // bready and rready stay high, so every answer is taken at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic awOk, wOk, bOk;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        do begin
            // ready is read mid-cycle, as it stands at the edge that takes the request
            @(negedge clk);
            awOk = s_axi_awready & s_axi_awvalid;
            wOk = s_axi_wready & s_axi_wvalid;
            bOk = s_axi_bvalid;
            @(posedge clk);
            if (awOk) s_axi_awvalid <= 1'b0;
            if (wOk) s_axi_wvalid <= 1'b0;
        end while (!bOk);
    endtask
    task automatic rdw(input logic [7:0] a);
        logic arOk, rOk;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            arOk = s_axi_arready & s_axi_arvalid;
            rOk = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge clk);
            if (arOk) s_axi_arvalid <= 1'b0;
        end while (!rOk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #60000;
        bad_count++;
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {bad_count, checks_done} = '0;
        {sys_rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
        {lineIn, pace, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wr(`OFS_DIR_HI, 32'h1);
        wr(`OFS_OUT_HI, 32'h1);
        wr(`OFS_DIR_LO, 32'h5);
        @(posedge clk);
        chk({lineOut[32], lineOeN[32], lineOeN[3:0]}, 6'b10_1010);
        wr(`OFS_DIR_LO, 32'h0);
        lineIn <= 40'ha5_cafe_1235;
        repeat (8) @(posedge clk);
        rdw(`OFS_IN_HI);
        chk(rd, 32'ha5);
        rdw(`OFS_IN_LO);
        chk(rd, 32'hcafe_1235);
        rdw(8'hfc);
        chk(rr, 2'h2);
        wr(8'hfc, 32'h0);
        chk(s_axi_bresp, 2'h2);
        $display("static lines done");
        pace <= 2'h1;
        wr(`OFS_CAPEN, 32'hffff_ffff);
        wr(`OFS_DIVISOR, 32'h4);
        wr(`OFS_TOTAL, 32'h3);
        wr(`OFS_DMA_BASE, 32'h100);
        wr(`OFS_CTRL, 32'h1);
        do rdw(`OFS_STATUS); while (rd[`STAT_RUN] !== 1'b0);
        repeat (20) @(posedge clk);
        chk(words, 3);
        chk(lastWord, 32'hcafe_1235);
        rdw(`OFS_DMA_SENT);
        chk(rd, 32'h3);
        wr(`OFS_CTRL, 32'h51);
        rdw(`OFS_STATUS);
        chk(rd[3:0], 4'h8);
        $display("finite capture done");
        lineIn[0] <= 1'b0;
        wr(`OFS_CTRL, 32'h1);
        repeat (200) @(posedge clk);
        rdw(`OFS_STATUS);
        chk({words[3:0], rd[0]}, 5'b0011_1);
        wr(`OFS_CTRL, 32'h2);
        rdw(`OFS_STATUS);
        chk(rd[0], 1'b0);
        lineIn[0] <= 1'b1;
        $display("hold done");
        wr(`OFS_CTRL, 32'h21);
        repeat (100) @(posedge clk);
        rdw(`OFS_TSP_DATA);
        chk(rd, 32'hcafe_1235);
        rdw(`OFS_STATUS);
        chk(rd[2], 1'b1);
        wr(`OFS_CTRL, 32'h2);
        $display("single point done");
        pace <= 2'h2;
        wr(`OFS_CTRL, 32'h11);
        repeat (300) @(posedge clk);
        rdw(`OFS_STATUS);
        chk({rd[5], rd[1:0]}, 3'b111);
        wr(`OFS_CTRL, 32'h2);
        pace <= 2'h0;
        repeat (40) @(posedge clk);
        rdw(`OFS_STATUS);
        chk({rd[5:4], rd[0]}, 3'b010);
        $display("overflow done");
        tally_and_finish;
    end
endmodule
